// ===== inc/rpm_map.svh
`ifndef RPM_MAP_SVH
`define RPM_MAP_SVH

// port A lines handled here
`define RPM_PA_WIDTH 3
`define RPM_LINE0 0
`define RPM_LINE1 1
`define RPM_LINE2 2

// synchroniser layout: reset pin, port A lines, comparator C result
`define RPM_SYNC_WIDTH 5
`define RPM_SYNC_RST_POS 0
`define RPM_SYNC_PA_LSB 1
`define RPM_SYNC_PA_MSB 3
`define RPM_SYNC_CMPC_POS 4
`define RPM_SYNC_RESET_VALUE 5'h1f

// reset sequencing
`define RPM_RST_RELEASE_CYCLES 16
`define RPM_RST_CNT_WIDTH 5
`define RPM_RST_CNT_LAST 5'h0f
`define RPM_RST_CNT_SAT 5'h1f

// pin defaults after reset
`define RPM_PA_OE_N_RESET 3'h7
`define RPM_PA_OUT_RESET 3'h0
`define RPM_PA_EN_RESET 3'h0

`endif

// ===== inc/rpm_pkg.sv
`include "rpm_map.svh"

package rpm_pkg;

    typedef enum logic {
        RPM_PIN_RESET_ROLE,
        RPM_PIN_PORT_ROLE
    } rpm_pin_role_t;

    typedef enum logic {
        RPM_A0_ANALOG,
        RPM_A0_CMPC_OUT
    } rpm_a0_func_t;

    typedef enum logic [1:0] {
        RPM_SEQ_HOLD,
        RPM_SEQ_COUNT,
        RPM_SEQ_RUN
    } rpm_seq_state_t;

    typedef struct packed {
        logic [`RPM_SYNC_WIDTH-1:0] stage1;
        logic [`RPM_SYNC_WIDTH-1:0] stage2;
    } rpm_sync_regs_t;

    typedef struct packed {
        rpm_seq_state_t state;
        logic [`RPM_RST_CNT_WIDTH-1:0] cnt;
        logic [`RPM_RST_CNT_WIDTH-1:0] low_cnt;
    } rpm_seq_regs_t;

    typedef struct packed {
        rpm_pin_role_t role;
        logic rst_oe_n;
        logic [`RPM_PA_WIDTH-1:0] pa_out;
        logic [`RPM_PA_WIDTH-1:0] pa_oe_n;
        logic [`RPM_PA_WIDTH-1:0] pa_in;
        logic pd4_in;
        logic [`RPM_PA_WIDTH-1:0] ch_en;
        logic cmp3_en;
        logic cmp0_en;
        logic cmp1_en;
        logic vrefh_en;
    } rpm_mux_regs_t;

endpackage : rpm_pkg

// ===== logic/rpm_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "rpm_map.svh"

module rpm_sync
    import rpm_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // asynchronous levels in, synchronised levels out
    input wire logic [`RPM_SYNC_WIDTH-1:0] async_i,
    output logic [`RPM_SYNC_WIDTH-1:0] sync_o
);

    rpm_sync_regs_t q;
    rpm_sync_regs_t d;

    // stage1 feeds stage2 only; idle level matches the pin pullups
    always_comb begin
        d = q;
        d.stage1 = async_i;
        d.stage2 = q.stage1;
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            q.stage1 <= `RPM_SYNC_RESET_VALUE;
            q.stage2 <= `RPM_SYNC_RESET_VALUE;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.stage2;

endmodule : rpm_sync

`default_nettype wire

// ===== logic/rpm_rst_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "rpm_map.svh"

module rpm_rst_seq
    import rpm_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // combined reset request, level
    input wire logic req_i,
    // internal reset, level
    output logic core_reset_o
);

    rpm_seq_regs_t q;
    rpm_seq_regs_t d;

    always_comb begin
        d = q;
        if (req_i) begin
            d.low_cnt = '0;
        end else if (q.low_cnt != `RPM_RST_CNT_SAT) begin
            d.low_cnt = q.low_cnt + 5'h01;
        end
        unique case (q.state)
            RPM_SEQ_HOLD: begin
                d.cnt = '0;
                if (!req_i) begin
                    d.state = RPM_SEQ_COUNT;
                end
            end
            RPM_SEQ_COUNT: begin
                if (req_i) begin
                    d.state = RPM_SEQ_HOLD;
                    d.cnt = '0;
                end else if (q.cnt == `RPM_RST_CNT_LAST) begin
                    d.state = RPM_SEQ_RUN;
                end else begin
                    d.cnt = q.cnt + 5'h01;
                end
            end
            RPM_SEQ_RUN: begin
                if (req_i) begin
                    d.state = RPM_SEQ_HOLD;
                    d.cnt = '0;
                end
            end
            default: begin
                d.state = RPM_SEQ_HOLD;
                d.cnt = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            q.state <= RPM_SEQ_HOLD;
            q.cnt <= '0;
            q.low_cnt <= '0;
        end else begin
            q <= d;
        end
    end

    assign core_reset_o = (q.state != RPM_SEQ_RUN);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    localparam int unsigned release_cycles = `RPM_RST_RELEASE_CYCLES;

    sequence s_req_then_drop;
        req_i ##1 !req_i;
    endsequence

    property p_release_count;
        $fell(core_reset_o) |-> (q.low_cnt == 5'(release_cycles + 1));
    endproperty
    a_release_count: assert property (p_release_count)
        else $error("internal reset released after wrong cycle count");

    property p_no_early_release;
        s_req_then_drop |-> core_reset_o [*2];
    endproperty
    a_no_early_release: assert property (p_no_early_release)
        else $error("internal reset released right after request");

endmodule : rpm_rst_seq

`default_nettype wire

// ===== logic/rpm_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none
`include "rpm_map.svh"

module rpm_pin_mux
    import rpm_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // shared reset pin, open drain
    input wire logic external_reset_n_i,
    output logic external_reset_n_o,
    output logic external_reset_n_oe_n_o,
    // other reset sources and internal reset
    input wire logic power_on_reset_i,
    input wire logic watchdog_reset_i,
    input wire logic software_reset_i,
    output logic core_reset_o,
    // reset pin port function
    input wire logic reset_pin_port_role_i,
    input wire logic port_d_line_4_dir_out_i,
    input wire logic port_d_line_4_data_i,
    output logic port_d_line_4_in_o,
    // port A lines 0 to 2
    input wire logic [`RPM_PA_WIDTH-1:0] port_a_i,
    output logic [`RPM_PA_WIDTH-1:0] port_a_o,
    output logic [`RPM_PA_WIDTH-1:0] port_a_oe_n_o,
    output logic [`RPM_PA_WIDTH-1:0] port_a_in_o,
    // port A configuration
    input wire logic [`RPM_PA_WIDTH-1:0] port_a_dir_out_i,
    input wire logic [`RPM_PA_WIDTH-1:0] port_a_data_i,
    input wire logic [`RPM_PA_WIDTH-1:0] port_peripheral_enable_i,
    input wire logic [`RPM_PA_WIDTH-1:0] system_peripheral_select_i,
    input wire rpm_a0_func_t port_a_line_0_func_i,
    input wire logic conv_a_ref_high_sel_i,
    // analog routing
    input wire logic comparator_c_result_i,
    output logic [`RPM_PA_WIDTH-1:0] conv_a_channel_en_o,
    output logic comparator_a_input_3_en_o,
    output logic comparator_a_input_0_en_o,
    output logic comparator_a_input_1_en_o,
    output logic conv_a_reference_high_en_o
);

    rpm_mux_regs_t q;
    rpm_mux_regs_t d;
    logic [`RPM_SYNC_WIDTH-1:0] sync_in;
    logic [`RPM_SYNC_WIDTH-1:0] sync_out;
    logic rst_pin_sync;
    logic cmpc_sync;
    logic [`RPM_PA_WIDTH-1:0] pa_sync;
    logic [`RPM_PA_WIDTH-1:0] alt;
    logic ext_req;
    logic seq_req;
    logic line0_analog;
    logic line0_cmpc;

    // comparator C result is asynchronous to the core clock too
    assign sync_in = {comparator_c_result_i, port_a_i, external_reset_n_i};

    rpm_sync u_sync (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .async_i(sync_in),
        .sync_o(sync_out)
    );

    assign rst_pin_sync = sync_out[`RPM_SYNC_RST_POS];
    assign pa_sync = sync_out[`RPM_SYNC_PA_MSB:`RPM_SYNC_PA_LSB];
    assign cmpc_sync = sync_out[`RPM_SYNC_CMPC_POS];

    // pin request, gated in port role
    assign ext_req = (q.role == RPM_PIN_RESET_ROLE) && !rst_pin_sync;
    assign seq_req = ext_req || power_on_reset_i || watchdog_reset_i || software_reset_i;

    rpm_rst_seq u_rst_seq (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .req_i(seq_req),
        .core_reset_o(core_reset_o)
    );

    assign alt = port_peripheral_enable_i & system_peripheral_select_i;
    assign line0_analog = alt[`RPM_LINE0] && (port_a_line_0_func_i == RPM_A0_ANALOG);
    assign line0_cmpc = alt[`RPM_LINE0] && (port_a_line_0_func_i == RPM_A0_CMPC_OUT);

    always_comb begin
        d = q;
        d.pa_in = pa_sync;
        if (core_reset_o) begin
            d.role = RPM_PIN_RESET_ROLE;
            d.rst_oe_n = 1'b1;
            d.pd4_in = 1'b1;
            d.pa_out = `RPM_PA_OUT_RESET;
            d.pa_oe_n = `RPM_PA_OE_N_RESET;
            d.ch_en = `RPM_PA_EN_RESET;
            d.cmp3_en = 1'b0;
            d.cmp0_en = 1'b0;
            d.cmp1_en = 1'b0;
            d.vrefh_en = 1'b0;
        end else begin
            d.role = reset_pin_port_role_i ? RPM_PIN_PORT_ROLE : RPM_PIN_RESET_ROLE;
            // pull low only, never drive high
            d.rst_oe_n = !(reset_pin_port_role_i && port_d_line_4_dir_out_i
                           && !port_d_line_4_data_i);
            d.pd4_in = (q.role == RPM_PIN_PORT_ROLE) ? rst_pin_sync : 1'b1;
            for (int n = 0; n < `RPM_PA_WIDTH; n++) begin
                if (alt[n]) begin
                    d.pa_out[n] = 1'b0;
                    d.pa_oe_n[n] = 1'b1;
                end else begin
                    d.pa_out[n] = port_a_data_i[n];
                    d.pa_oe_n[n] = !port_a_dir_out_i[n];
                end
            end
            // comparator C result onto line 0
            if (line0_cmpc) begin
                d.pa_out[`RPM_LINE0] = cmpc_sync;
                d.pa_oe_n[`RPM_LINE0] = 1'b0;
            end
            d.ch_en[`RPM_LINE0] = line0_analog;
            d.cmp3_en = line0_analog;
            d.ch_en[`RPM_LINE1] = alt[`RPM_LINE1];
            d.cmp0_en = alt[`RPM_LINE1];
            d.ch_en[`RPM_LINE2] = alt[`RPM_LINE2] && !conv_a_ref_high_sel_i;
            d.cmp1_en = alt[`RPM_LINE2] && !conv_a_ref_high_sel_i;
            d.vrefh_en = alt[`RPM_LINE2] && conv_a_ref_high_sel_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            q.role <= RPM_PIN_RESET_ROLE;
            q.rst_oe_n <= 1'b1;
            q.pa_out <= `RPM_PA_OUT_RESET;
            q.pa_oe_n <= `RPM_PA_OE_N_RESET;
            q.pa_in <= `RPM_PA_OUT_RESET;
            q.pd4_in <= 1'b1;
            q.ch_en <= `RPM_PA_EN_RESET;
            q.cmp3_en <= 1'b0;
            q.cmp0_en <= 1'b0;
            q.cmp1_en <= 1'b0;
            q.vrefh_en <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // pin output level is constant low; only the enable moves
    assign external_reset_n_o = 1'b0;
    assign external_reset_n_oe_n_o = q.rst_oe_n;
    assign port_d_line_4_in_o = q.pd4_in;
    assign port_a_o = q.pa_out;
    assign port_a_oe_n_o = q.pa_oe_n;
    assign port_a_in_o = q.pa_in;
    assign conv_a_channel_en_o = q.ch_en;
    assign comparator_a_input_3_en_o = q.cmp3_en;
    assign comparator_a_input_0_en_o = q.cmp0_en;
    assign comparator_a_input_1_en_o = q.cmp1_en;
    assign conv_a_reference_high_en_o = q.vrefh_en;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    property p_ext_reset;
        ext_req |=> core_reset_o;
    endproperty
    a_ext_reset: assert property (p_ext_reset)
        else $error("low reset pin did not hold internal reset");

    property p_pin_default;
        core_reset_o |=> (q.role == RPM_PIN_RESET_ROLE) && external_reset_n_oe_n_o;
    endproperty
    a_pin_default: assert property (p_pin_default)
        else $error("reset pin not in reset role after reset");

    property p_open_drain;
        (!core_reset_o && reset_pin_port_role_i && port_d_line_4_dir_out_i
         && !port_d_line_4_data_i) |=> !external_reset_n_oe_n_o && !external_reset_n_o;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("port role output low not driven");

    property p_never_high;
        !external_reset_n_oe_n_o |-> !external_reset_n_o && $past(reset_pin_port_role_i);
    endproperty
    a_never_high: assert property (p_never_high)
        else $error("reset pin driven outside pull-low port use");

    // a low pin in port role must leave a running device running
    property p_port_no_reset;
        (q.role == RPM_PIN_PORT_ROLE) && !rst_pin_sync && !core_reset_o && !power_on_reset_i
            && !watchdog_reset_i && !software_reset_i |=> !core_reset_o;
    endproperty
    a_port_no_reset: assert property (p_port_no_reset)
        else $error("low pin reset the device in port role");

    property p_other_resets;
        (power_on_reset_i || watchdog_reset_i || software_reset_i) |=> core_reset_o [*2];
    endproperty
    a_other_resets: assert property (p_other_resets)
        else $error("internal reset source ignored");

    property p_pa_default;
        core_reset_o |=> (port_a_oe_n_o == `RPM_PA_OE_N_RESET) && (conv_a_channel_en_o == '0)
                         && !conv_a_reference_high_en_o;
    endproperty
    a_pa_default: assert property (p_pa_default)
        else $error("port A not general-purpose input during reset");

    property p_line0;
        (!core_reset_o && line0_analog) |=> conv_a_channel_en_o[0] && comparator_a_input_3_en_o
                                             && port_a_oe_n_o[0];
    endproperty
    a_line0: assert property (p_line0)
        else $error("line 0 analog routing wrong");

    property p_line1;
        (!core_reset_o && alt[`RPM_LINE1]) |=> conv_a_channel_en_o[1]
                                               && comparator_a_input_0_en_o;
    endproperty
    a_line1: assert property (p_line1)
        else $error("line 1 analog routing wrong");

    property p_line2;
        (!core_reset_o && alt[`RPM_LINE2]) |=> (conv_a_reference_high_en_o
            == $past(conv_a_ref_high_sel_i)) && (comparator_a_input_1_en_o
            == conv_a_channel_en_o[2]) && (conv_a_channel_en_o[2] != conv_a_reference_high_en_o);
    endproperty
    a_line2: assert property (p_line2)
        else $error("line 2 channel or reference choice wrong");

    property p_cmpc;
        (!core_reset_o && line0_cmpc) |=> !port_a_oe_n_o[0] && (port_a_o[0] == $past(cmpc_sync));
    endproperty
    a_cmpc: assert property (p_cmpc)
        else $error("comparator C result not on line 0");

    property p_alt_gate;
        (conv_a_channel_en_o[1] || conv_a_channel_en_o[2] || conv_a_reference_high_en_o)
            |-> $past(alt) != '0;
    endproperty
    a_alt_gate: assert property (p_alt_gate)
        else $error("alternate function without both enables");

    property p_sync_delay;
        (!$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3))
            |-> (rst_pin_sync == $past(external_reset_n_i, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("reset pin not delayed by two flops");

endmodule : rpm_pin_mux

`default_nettype wire

// ===== testbench/rpm_board_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "rpm_map.svh"

module rpm_board_model (
    // board-side controls
    input wire logic rst_pull_low_i,
    input wire logic [`RPM_PA_WIDTH-1:0] src_level_i,
    // device pin drivers
    input wire logic rst_pin_data_i,
    input wire logic rst_pin_oe_n_i,
    input wire logic [`RPM_PA_WIDTH-1:0] pa_data_i,
    input wire logic [`RPM_PA_WIDTH-1:0] pa_oe_n_i,
    // resolved pin levels
    output logic rst_pin_o,
    output logic [`RPM_PA_WIDTH-1:0] pa_pin_o
);
    // pull-up wins unless the board or the device pulls low
    assign rst_pin_o = !(rst_pull_low_i || (!rst_pin_oe_n_i && !rst_pin_data_i));
    // analog source is overridden wherever the device drives
    assign pa_pin_o = (pa_data_i & ~pa_oe_n_i) | (src_level_i & pa_oe_n_i);
endmodule : rpm_board_model
`default_nettype wire

// ===== testbench/rpm_pin_mux_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "rpm_map.svh"

module rpm_pin_mux_bench;
    import rpm_pkg::*;
    logic clk, rst, por, wdog, swr, role, d4_dir, d4_dat, pull, ref_sel, cmpc;
    logic [`RPM_PA_WIDTH-1:0] pa_dir, pa_dat, pe, sps, src;
    rpm_a0_func_t func;
    logic rst_pin, rst_out, rst_oe_n, core_rst, d4_in, c3, c0, c1, vref;
    logic [`RPM_PA_WIDTH-1:0] pa_pin, pa_o, pa_oe_n, pa_in, ch_en;
    logic [2:0] cmp_exp [0:2] = '{3'h4, 3'h2, 3'h1};
    int n_fail = 0;
    int n_compared = 0;

    rpm_pin_mux dut (
        .core_clk_i(clk), .reset_i(rst),
        .external_reset_n_i(rst_pin), .external_reset_n_o(rst_out),
        .external_reset_n_oe_n_o(rst_oe_n),
        .power_on_reset_i(por), .watchdog_reset_i(wdog), .software_reset_i(swr),
        .core_reset_o(core_rst), .reset_pin_port_role_i(role),
        .port_d_line_4_dir_out_i(d4_dir), .port_d_line_4_data_i(d4_dat),
        .port_d_line_4_in_o(d4_in),
        .port_a_i(pa_pin), .port_a_o(pa_o), .port_a_oe_n_o(pa_oe_n), .port_a_in_o(pa_in),
        .port_a_dir_out_i(pa_dir), .port_a_data_i(pa_dat),
        .port_peripheral_enable_i(pe), .system_peripheral_select_i(sps),
        .port_a_line_0_func_i(func), .conv_a_ref_high_sel_i(ref_sel),
        .comparator_c_result_i(cmpc), .conv_a_channel_en_o(ch_en),
        .comparator_a_input_3_en_o(c3), .comparator_a_input_0_en_o(c0),
        .comparator_a_input_1_en_o(c1), .conv_a_reference_high_en_o(vref)
    );

    rpm_board_model board (
        .rst_pull_low_i(pull), .src_level_i(src),
        .rst_pin_data_i(rst_out), .rst_pin_oe_n_i(rst_oe_n),
        .pa_data_i(pa_o), .pa_oe_n_i(pa_oe_n),
        .rst_pin_o(rst_pin), .pa_pin_o(pa_pin)
    );

    always #5 clk = ~clk;

    task tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : look

    // counts edges from the current edge until the core reset drops
    task count_release(input int exp);
        int k;
        k = 0;
        while (core_rst !== 1'h0 && k < 40) begin
            look(1);
            k++;
        end
        check(k, exp);
    endtask : count_release

    task t_reset_defaults;
        pe <= 3'h7;
        sps <= 3'h7;
        look(2);
        check(core_rst, 1'h1);
        check({rst_oe_n, d4_in}, 2'h3);
        check(pa_oe_n, 3'h7);
        check(ch_en, 3'h0);
        @(posedge clk);
        rst <= 1'h0;
        count_release(17);
        check(ch_en, 3'h0);
        look(1);
        check(ch_en, 3'h7);
        @(posedge clk);
        pe <= 3'h0;
        sps <= 3'h0;
        $display("test reset defaults finished");
    endtask : t_reset_defaults

    task t_pin_reset;
        @(posedge clk);
        pull <= 1'h1;
        look(2);
        check(core_rst, 1'h0);
        look(1);
        check(core_rst, 1'h1);
        look(5);
        @(posedge clk);
        pull <= 1'h0;
        count_release(19);
        $display("test pin reset finished");
    endtask : t_pin_reset

    task t_port_role;
        @(posedge clk);
        role <= 1'h1;
        d4_dir <= 1'h1;
        d4_dat <= 1'h0;
        look(1);
        check({rst_oe_n, rst_out}, 2'h0);
        look(4);
        check({core_rst, d4_in}, 2'h0);
        @(posedge clk);
        d4_dat <= 1'h1;
        look(1);
        check(rst_oe_n, 1'h1);
        @(posedge clk);
        d4_dir <= 1'h0;
        pull <= 1'h1;
        look(4);
        check({core_rst, d4_in}, 2'h0);
        @(posedge clk);
        pull <= 1'h0;
        look(3);
        // each remaining source must still reset with the pin gated
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            {por, wdog, swr} <= 3'h1 << i;
            look(1);
            check(core_rst, 1'h1);
            check(rst_oe_n, 1'h1);
            @(posedge clk);
            {por, wdog, swr} <= 3'h0;
            count_release(17);
        end
        @(posedge clk);
        role <= 1'h0;
        $display("test port role finished");
    endtask : t_port_role

    task t_analog;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            pe <= 3'h1 << i;
            sps <= 3'h0;
            look(1);
            check({c3, c0, c1, ch_en}, 6'h0);
            @(posedge clk);
            sps <= 3'h1 << i;
            look(1);
            check(ch_en, 3'h1 << i);
            check({c3, c0, c1}, cmp_exp[i]);
        end
        @(posedge clk);
        ref_sel <= 1'h1;
        look(1);
        check({vref, ch_en[2], c1}, 3'h4);
        @(posedge clk);
        ref_sel <= 1'h0;
        pe <= 3'h0;
        sps <= 3'h0;
        $display("test analog routing finished");
    endtask : t_analog

    task t_cmpc;
        @(posedge clk);
        func <= RPM_A0_CMPC_OUT;
        pe <= 3'h1;
        sps <= 3'h1;
        cmpc <= 1'h1;
        look(3);
        check({pa_oe_n[0], pa_o[0]}, 2'h1);
        @(posedge clk);
        cmpc <= 1'h0;
        look(2);
        check(pa_o[0], 1'h1);
        look(1);
        check(pa_o[0], 1'h0);
        @(posedge clk);
        func <= RPM_A0_ANALOG;
        pe <= 3'h0;
        sps <= 3'h0;
        $display("test comparator output finished");
    endtask : t_cmpc

    task t_gpio;
        @(posedge clk);
        pa_dir <= 3'h5;
        pa_dat <= 3'h4;
        src <= 3'h2;
        look(1);
        check(pa_oe_n, 3'h2);
        check({pa_o[2], pa_o[0]}, 2'h2);
        // driven levels reach the pin one edge late, then three more to the input register
        look(3);
        check(pa_in, 3'h6);
        $display("test port a gpio finished");
    endtask : t_gpio

    initial begin
        clk = 1'h0;
        rst = 1'h1;
        {por, wdog, swr, role, d4_dir, d4_dat, pull, ref_sel, cmpc} = 9'h0;
        {pa_dir, pa_dat, pe, sps, src} = 15'h0;
        func = RPM_A0_ANALOG;
        t_reset_defaults();
        t_pin_reset();
        t_port_role();
        t_analog();
        t_cmpc();
        t_gpio();
        tally_and_finish();
    end

    // the full run needs under two hundred cycles
    initial begin
        #20000;
        n_fail++;
        $display("wrong value at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule : rpm_pin_mux_bench
`default_nettype wire
